// >>> rtl/osc_ctrl_cfg.svh
// constants for the oscillator control block: offsets, fields, timing
// assumes a 100 MHz core clock and a 16-bit register port
`ifndef OSC_CTRL_CFG_SVH
`define OSC_CTRL_CFG_SVH

// ----------------------------------------------------------------------
// register offsets (word index on the register port)
// ----------------------------------------------------------------------
`define OFS_OSC_CONTROL 4'h0
`define OFS_UNLOCK_KEY 4'h1
`define OFS_IRQ_STATUS 4'h2
`define OFS_IRQ_MASK 4'h3

// ----------------------------------------------------------------------
// oscillator control fields
// ----------------------------------------------------------------------
`define BIT_SWITCH_REQUEST 0
`define BIT_SECONDARY_EN 1
`define BIT_PRIMARY_SLEEP 2
`define BIT_CLOCK_FAIL 3
`define BIT_UNUSED 4
`define BIT_PLL_SETTLED 5
`define BIT_PIN_MAP_FREEZE 6
`define BIT_CLOCK_FREEZE 7
`define NEW_SEL_LSB 8
`define CUR_SEL_LSB 12

// ----------------------------------------------------------------------
// unlock keys and interrupt bits
// ----------------------------------------------------------------------
`define UNLOCK_KEY_FIRST 8'h55
`define UNLOCK_KEY_SECOND 8'hAA
`define IRQ_BIT_CLOCK_FAIL 0
`define IRQ_BIT_SWITCH_DONE 1
`define IRQ_BIT_PLL_SETTLED 2
`define IRQ_WIDTH 3
`define IRQ_RESET 3'h0

// ----------------------------------------------------------------------
// selection codes whose clock path runs through the pll
// ----------------------------------------------------------------------
`define SEL_PLL_A 3'h1
`define SEL_PLL_B 3'h3

// ----------------------------------------------------------------------
// timing: figures in ns, counts derived from the clock period
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define SWITCH_TIME_NS 2000
`define PLL_START_TIME_NS 2000
`define SWITCH_CYCLES ((`SWITCH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PLL_START_CYCLES \
  ((`PLL_START_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> rtl/osc_ctrl_pkg.sv
// types shared by the oscillator control block and its surroundings
// assumes the constants header is compiled alongside
package osc_ctrl_pkg;

  // ----------------------------------------------------------------------
  // register port request
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;   // word index
    logic [15:0] wdata; // write data
    logic wr;           // write strobe
    logic rd;           // read strobe
  } bus_req_t;

  // clock source selection code
  typedef logic [2:0] osc_sel_t;

  // ----------------------------------------------------------------------
  // low byte of the oscillator control word, msb first
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic clock_select_freeze;
    logic pin_map_freeze;
    logic pll_settled;
    logic unused;
    logic clock_fail_flag;
    logic primary_osc_sleep_keep;
    logic secondary_osc_enable;
    logic osc_switch_request;
  } ctrl_low_t;

  // switch sequencer states
  typedef enum logic [1:0] {
    SW_IDLE = 2'b01,
    SW_BUSY = 2'b10
  } switch_state_t;

  // pin-map unlock sequence states
  typedef enum logic [2:0] {
    UL_LOCKED = 3'b001,
    UL_HALF = 3'b010,
    UL_OPEN = 3'b100
  } unlock_state_t;

endpackage : osc_ctrl_pkg

// >>> rtl/oscillator_control_low_byte.sv
// oscillator control register with switch sequencer and pll status
// assumes synchronous inputs on core_clk_in and a one-cycle read port
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "osc_ctrl_cfg.svh"

// Behaviour
// R1: monitor on and freeze set blocks selection changes
// R2: monitor off never freezes clock selection
// R3: pin-map freeze bit shows mapping lock state
// R4: pin-map freeze changes only after unlock sequence
// R5: one-way config keeps pin-map freeze set
// R6: pll settled when locked or start timer done
// R7: pll settled zero during switch, non-pll mode
// R8: clock fail flag set on monitor failure
// R9: primary oscillator runs in sleep when enabled
// R10: secondary oscillator enable turns it on/off
// R11: switch request starts switch to new selection
// R12: hardware clears switch request when done
// R13: unused bit ignores writes, reads zero
// R14: selection reset values come from initial config
// R15: clock fail flag sticky until software clears
module oscillator_control_low_byte (
  input wire logic core_clk_in,                        // core clock
  input wire logic rstn_in,                            // async reset, low
  input wire osc_ctrl_pkg::bus_req_t bus_req_in,       // register request
  output logic [15:0] rdata_out,                       // read data
  input wire logic monitor_config_bit_in,              // monitor enabled
  input wire logic io_one_shot_config_in,              // one-way freeze
  input wire osc_ctrl_pkg::osc_sel_t initial_osc_config_in, // boot source
  input wire logic clock_fail_detect_in,               // monitor failure
  input wire logic pll_in_lock_in,                     // pll lock detect
  input wire logic sleep_in,                           // sleep mode active
  output logic primary_osc_run_out,                    // primary osc on
  output logic secondary_osc_on_out,                   // secondary osc on
  output osc_ctrl_pkg::osc_sel_t current_osc_out,      // active source
  output logic switch_busy_out,                        // switch running
  output logic pin_map_lock_out,                       // mapping locked
  output logic irq_out                                 // level interrupt
);
  import osc_ctrl_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // true for the selection codes that use the pll
  function automatic logic is_pll_mode(input osc_sel_t sel);
    is_pll_mode = (sel == `SEL_PLL_A) || (sel == `SEL_PLL_B);
  endfunction : is_pll_mode

  localparam logic [7:0] SWITCH_LAST = 8'(`SWITCH_CYCLES - 1);
  localparam logic [7:0] PLL_LAST = 8'(`PLL_START_CYCLES - 1);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic loaded;                    // boot selection captured
  osc_sel_t new_osc_select;        // requested source
  osc_sel_t current_osc;           // active source
  logic clock_select_freeze;       // selection freeze bit
  logic pin_map_freeze;            // pin mapping freeze bit
  logic clock_fail_flag;           // sticky failure flag
  logic primary_osc_sleep_keep;    // primary runs in sleep
  logic secondary_osc_enable;      // secondary osc enable
  switch_state_t sw_state;         // switch sequencer
  logic [7:0] sw_count;            // switch settle counter
  logic [7:0] pll_count;           // pll start-up counter
  logic pll_timer_done;            // start-up timer expired
  unlock_state_t ul_state;         // unlock sequencer
  logic [`IRQ_WIDTH-1:0] irq_status; // sticky events
  logic [`IRQ_WIDTH-1:0] irq_mask;   // event enables
  logic pll_settled_q;             // previous settled value
  logic [15:0] rdata;              // read data register

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire wr_ctrl = bus_req_in.wr && (bus_req_in.addr == `OFS_OSC_CONTROL);
  wire wr_key = bus_req_in.wr && (bus_req_in.addr == `OFS_UNLOCK_KEY);
  wire wr_stat = bus_req_in.wr && (bus_req_in.addr == `OFS_IRQ_STATUS);
  wire wr_mask = bus_req_in.wr && (bus_req_in.addr == `OFS_IRQ_MASK);
  wire [7:0] wkey = bus_req_in.wdata[7:0];
  wire [15:0] wd = bus_req_in.wdata;

  // freeze only counts while the monitor is configured on
  wire sel_frozen = monitor_config_bit_in && clock_select_freeze; // [R1] [R2]
  wire sel_writable = wr_ctrl && !sel_frozen;                      // [R1] [R2]
  wire switch_start = sel_writable && wd[`BIT_SWITCH_REQUEST] &&
                      (sw_state == SW_IDLE) && loaded;             // [R11]
  wire switch_done = (sw_state == SW_BUSY) && (sw_count == SWITCH_LAST);

  // pin-map freeze changes only through an open unlock window
  wire pm_write = wr_ctrl && (ul_state == UL_OPEN);                // [R4]
  wire pm_new = wd[`BIT_PIN_MAP_FREEZE];
  wire pm_clear_blocked = io_one_shot_config_in && pin_map_freeze; // [R5]
  wire next_pin_map = (pm_write && !(pm_clear_blocked && !pm_new)) ?
                      pm_new : pin_map_freeze;                     // [R4] [R5]

  // pll settled: pll path, not switching, and locked or timer done
  wire pll_mode = is_pll_mode(current_osc);
  wire pll_settled = pll_mode && (sw_state == SW_IDLE) &&
                     (pll_in_lock_in || pll_timer_done);           // [R6] [R7]

  // low byte as software sees it
  ctrl_low_t low;
  assign low.clock_select_freeze = clock_select_freeze;
  assign low.pin_map_freeze = pin_map_freeze;                      // [R3]
  assign low.pll_settled = pll_settled;                            // [R6]
  assign low.unused = 1'b0;                                        // [R13]
  assign low.clock_fail_flag = clock_fail_flag;                    // [R8]
  assign low.primary_osc_sleep_keep = primary_osc_sleep_keep;
  assign low.secondary_osc_enable = secondary_osc_enable;
  assign low.osc_switch_request = (sw_state == SW_BUSY);           // [R12]

  wire [15:0] ctrl_word = {1'b0, current_osc, 1'b0, new_osc_select, low};

  // event sources for the interrupt status
  wire [`IRQ_WIDTH-1:0] irq_events = {
    pll_settled && !pll_settled_q,
    switch_done,
    clock_fail_detect_in
  };

  // read multiplexer; unmapped offsets read zero
  wire [15:0] next_rdata =
    !bus_req_in.rd ? 16'h0000 :
    (bus_req_in.addr == `OFS_OSC_CONTROL) ? ctrl_word :
    (bus_req_in.addr == `OFS_IRQ_STATUS) ? {13'h0000, irq_status} :
    (bus_req_in.addr == `OFS_IRQ_MASK) ? {13'h0000, irq_mask} :
    16'h0000;

  // ----------------------------------------------------------------------
  // boot selection capture
  // ----------------------------------------------------------------------
  // the strap is caught on the first clock after release, not in reset
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      loaded <= 1'b0;
    end else begin
      loaded <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // selection registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      new_osc_select <= 3'h0;
      current_osc <= 3'h0;
    end else if (!loaded) begin
      new_osc_select <= initial_osc_config_in;           // [R14]
      current_osc <= initial_osc_config_in;              // [R14]
    end else begin
      if (sel_writable && (sw_state == SW_IDLE)) begin
        new_osc_select <= wd[`NEW_SEL_LSB +: 3];          // [R1]
      end
      if (switch_done) begin
        current_osc <= new_osc_select;                   // [R11]
      end
    end
  end

  // ----------------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------------
  // the selection freeze can be set but only reset clears it
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clock_select_freeze <= 1'b0;
      pin_map_freeze <= 1'b0;
      primary_osc_sleep_keep <= 1'b0;
      secondary_osc_enable <= 1'b0;
    end else begin
      if (wr_ctrl && wd[`BIT_CLOCK_FREEZE]) begin
        clock_select_freeze <= 1'b1;
      end
      pin_map_freeze <= next_pin_map;                    // [R4] [R5]
      if (wr_ctrl) begin
        primary_osc_sleep_keep <= wd[`BIT_PRIMARY_SLEEP];
        secondary_osc_enable <= wd[`BIT_SECONDARY_EN];
      end
    end
  end

  // ----------------------------------------------------------------------
  // clock fail flag
  // ----------------------------------------------------------------------
  // writing zero clears it; a failure in the same cycle still sets it
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clock_fail_flag <= 1'b0;
    end else if (clock_fail_detect_in) begin
      clock_fail_flag <= 1'b1;                           // [R8] [R15]
    end else if (wr_ctrl && !wd[`BIT_CLOCK_FAIL]) begin
      clock_fail_flag <= 1'b0;                           // [R15]
    end
  end

  // ----------------------------------------------------------------------
  // switch sequencer
  // ----------------------------------------------------------------------
  // a request is held for a fixed settle time, then the source moves
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sw_state <= SW_IDLE;
      sw_count <= 8'h00;
    end else begin
      case (sw_state)
        SW_IDLE: begin
          sw_count <= 8'h00;
          if (switch_start) begin
            sw_state <= SW_BUSY;                         // [R11]
          end
        end
        SW_BUSY: begin
          sw_count <= sw_count + 8'h01;
          if (switch_done) begin
            sw_state <= SW_IDLE;                         // [R12]
          end
        end
        default: begin
          sw_state <= SW_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // pll start-up timer
  // ----------------------------------------------------------------------
  // restarts on every switch and whenever the pll path is left
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pll_count <= 8'h00;
      pll_timer_done <= 1'b0;
    end else if (!pll_mode || (sw_state == SW_BUSY)) begin
      pll_count <= 8'h00;                                // [R7]
      pll_timer_done <= 1'b0;                            // [R7]
    end else if (!pll_timer_done) begin
      pll_count <= pll_count + 8'h01;
      pll_timer_done <= (pll_count == PLL_LAST);         // [R6]
    end
  end

  // ----------------------------------------------------------------------
  // pin-map unlock sequence
  // ----------------------------------------------------------------------
  // two consecutive key writes open one control write; any other
  // register write in between starts the sequence over
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ul_state <= UL_LOCKED;
    end else if (bus_req_in.wr) begin
      case (ul_state)
        UL_LOCKED: begin
          ul_state <= (wr_key && wkey == `UNLOCK_KEY_FIRST) ?
                      UL_HALF : UL_LOCKED;               // [R4]
        end
        UL_HALF: begin
          ul_state <= (wr_key && wkey == `UNLOCK_KEY_SECOND) ?
                      UL_OPEN : UL_LOCKED;               // [R4]
        end
        UL_OPEN: begin
          ul_state <= UL_LOCKED;
        end
        default: begin
          ul_state <= UL_LOCKED;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------------
  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_status <= `IRQ_RESET;
      irq_mask <= `IRQ_RESET;
      pll_settled_q <= 1'b0;
    end else begin
      irq_status <= (irq_status &
                     ~(wr_stat ? wd[`IRQ_WIDTH-1:0] : `IRQ_RESET)) |
                    irq_events;
      if (wr_mask) begin
        irq_mask <= wd[`IRQ_WIDTH-1:0];
      end
      pll_settled_q <= pll_settled;
    end
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign rdata_out = rdata;
  // primary stops in sleep unless kept
  assign primary_osc_run_out = !sleep_in || primary_osc_sleep_keep; // [R9]
  assign secondary_osc_on_out = secondary_osc_enable;            // [R10]
  assign current_osc_out = current_osc;
  assign switch_busy_out = (sw_state == SW_BUSY);
  assign pin_map_lock_out = pin_map_freeze;                      // [R3]
  assign irq_out = |(irq_status & irq_mask);

endmodule : oscillator_control_low_byte

// >>> sim/osc_ctrl_asserts.sv
// concurrent checks on the oscillator control block ports
// assumes the package and constants header are compiled first
`timescale 1ns/1ps
`include "osc_ctrl_cfg.svh"
module osc_ctrl_asserts (
  input wire logic core_clk_in,                       // core clock
  input wire logic rstn_in,                           // async reset, low
  input wire osc_ctrl_pkg::bus_req_t bus_req_in,      // register request
  input wire logic [15:0] rdata_out,                  // read data
  input wire logic io_one_shot_config_in,             // one-way freeze
  input wire logic sleep_in,                          // sleep mode
  input wire logic primary_osc_run_out,               // primary osc on
  input wire logic secondary_osc_on_out,              // secondary osc on
  input wire osc_ctrl_pkg::osc_sel_t current_osc_out, // active source
  input wire logic switch_busy_out,                   // switch running
  input wire logic pin_map_lock_out                   // mapping locked
);
  import osc_ctrl_pkg::*;
  // ----------------------------------------------------------------------
  // clocking and named steps
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);
  // read strobe aimed at the control word
  sequence s_rd_ctrl;
    bus_req_in.rd && bus_req_in.addr == `OFS_OSC_CONTROL;
  endsequence
  // switch launch
  sequence s_sw_start;
    $rose(switch_busy_out);
  endsequence
  // busy stretch, loose bounds since the exact count is a design choice
  sequence s_sw_run;
    (switch_busy_out throughout ##180 1'h1) ##[1:40] !switch_busy_out;
  endsequence
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  chk_switch_length: assert property (s_sw_start |-> s_sw_run)
    else $error("switch busy time out of range");
  chk_unused_zero: assert property (s_rd_ctrl |=> !rdata_out[4])
    else $error("unused bit read as one");
  chk_pll_in_switch: assert property (
    (s_rd_ctrl ##0 switch_busy_out) |=> !rdata_out[5])
    else $error("pll status high during switch");
  chk_request_bit: assert property (
    s_rd_ctrl |=> rdata_out[0] == $past(switch_busy_out))
    else $error("switch request bit disagrees with busy");
  chk_cur_field: assert property (
    s_rd_ctrl |=> rdata_out[14:12] == $past(current_osc_out))
    else $error("current source field disagrees with output");
  chk_pin_field: assert property (
    s_rd_ctrl |=> rdata_out[6] == $past(pin_map_lock_out))
    else $error("pin map freeze bit disagrees with lock");
  chk_sec_field: assert property (
    s_rd_ctrl |=> rdata_out[1] == $past(secondary_osc_on_out))
    else $error("secondary enable bit disagrees with output");
  chk_primary_awake: assert property (
    !sleep_in |-> primary_osc_run_out)
    else $error("primary oscillator stopped while awake");
  chk_lock_oneway: assert property (
    io_one_shot_config_in && pin_map_lock_out |=> pin_map_lock_out)
    else $error("one-way pin map lock was cleared");
  chk_cur_change: assert property (
    $changed(current_osc_out) && $past(rstn_in, 2) |-> $fell(switch_busy_out))
    else $error("source changed outside switch completion");
endmodule : osc_ctrl_asserts

// >>> sim/testbench.sv
// self-checking bench for the oscillator control block
// assumes package, header and checker are compiled before it
`timescale 1ns/1ps
`include "osc_ctrl_cfg.svh"
module testbench;
  import osc_ctrl_pkg::*;
  logic core_clk_in, rstn_in, mon_cfg, one_way, fail_det, pll_lock, sleep;
  bus_req_t bus_req; // register request
  osc_sel_t init_sel, cur_osc, m_cur, m_new; // boot, active, model selections
  logic [15:0] rdata, lfsr, rd_val; // read data, random state, last read
  logic prim_run, sec_on, busy, pin_lock, irq; // design outputs
  logic [7:0] m_low; // model of the low byte
  int mismatches, cmp_count; // tallies
  // ----------------------------------------------------------------------
  // design and clock
  // ----------------------------------------------------------------------
  oscillator_control_low_byte dut_u (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .bus_req_in(bus_req),
    .rdata_out(rdata), .monitor_config_bit_in(mon_cfg),
    .io_one_shot_config_in(one_way), .initial_osc_config_in(init_sel),
    .clock_fail_detect_in(fail_det), .pll_in_lock_in(pll_lock),
    .sleep_in(sleep), .primary_osc_run_out(prim_run),
    .secondary_osc_on_out(sec_on), .current_osc_out(cur_osc),
    .switch_busy_out(busy), .pin_map_lock_out(pin_lock), .irq_out(irq));
  initial begin
    core_clk_in = 1'h0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one strobe cycle, held to the sampling edge; read data into rd_val
  task automatic bus(input logic [3:0] a, input logic [15:0] d,
                     input logic w);
    @(posedge core_clk_in);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge core_clk_in);
    bus_req <= '0;
    #1;
    rd_val = rdata;
  endtask : bus
  task automatic wr_ctrl(input osc_sel_t sel, input logic [7:0] low);
    bus(`OFS_OSC_CONTROL, {5'h00, sel, low}, 1'h1);
  endtask : wr_ctrl
  // read the control word and hold it against the model
  task automatic cmp_ctrl();
    bus(`OFS_OSC_CONTROL, 16'h0000, 1'h0);
    check(rd_val, {1'h0, m_cur, 1'h0, m_new, m_low});
  endtask : cmp_ctrl
  task automatic unlock();
    bus(`OFS_UNLOCK_KEY, {8'h00, `UNLOCK_KEY_FIRST}, 1'h1);
    bus(`OFS_UNLOCK_KEY, {8'h00, `UNLOCK_KEY_SECOND}, 1'h1);
  endtask : unlock
  // request a switch; ok says whether it should be accepted
  task automatic sw(input osc_sel_t code, input logic ok);
    int n;
    wr_ctrl(code, m_low | 8'h01);
    check(busy, ok);
    if (ok) begin
      m_new = code;
      m_low[0] = 1'h1;
      m_low[5] = 1'h0;
    end
    cmp_ctrl();
    n = 0;
    while (busy !== 1'h0 && n < 400) begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    m_cur = m_new;
    m_low[0] = 1'h0;
    check(busy, 1'h0);
    check(cur_osc, m_cur);
  endtask : sw
  task automatic irq_is(input logic exp);
    @(posedge core_clk_in);
    #1;
    check(irq, exp);
  endtask : irq_is
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rstn_in = 1'h0;
    bus_req = '0;
    {mon_cfg, one_way, fail_det, pll_lock, sleep} = 5'h00;
    init_sel = 3'h2;
    mismatches = 0;
    cmp_count = 0;
    lfsr = 16'h003B;
    repeat (20) @(posedge core_clk_in);
    rstn_in <= 1'h1;
    repeat (2) @(posedge core_clk_in);
    {m_cur, m_new, m_low} = {3'h2, 3'h2, 8'h00};
    cmp_ctrl();
    check(prim_run, 1'h1);
    bus(4'h9, 16'hFFFF, 1'h1);
    bus(4'h9, 16'h0000, 1'h0);
    check(rd_val, 16'h0000);
    bus(`OFS_UNLOCK_KEY, 16'h0000, 1'h0);
    check(rd_val, 16'h0000);
    // loose bits: unused position and oscillator enables
    wr_ctrl(m_new, 8'h16);
    m_low = 8'h06;
    cmp_ctrl();
    check(sec_on, 1'h1);
    @(posedge core_clk_in);
    sleep <= 1'h1;
    #1;
    check(prim_run, 1'h1);
    wr_ctrl(m_new, 8'h02);
    m_low = 8'h02;
    check(prim_run, 1'h0);
    sleep <= 1'h0;
    // pin map freeze: refused, opened, broken sequence, one-way
    wr_ctrl(m_new, m_low | 8'h40);
    cmp_ctrl();
    unlock();
    wr_ctrl(m_new, m_low | 8'h40);
    m_low[6] = 1'h1;
    cmp_ctrl();
    check(pin_lock, 1'h1);
    bus(`OFS_UNLOCK_KEY, {8'h00, `UNLOCK_KEY_FIRST}, 1'h1);
    wr_ctrl(m_new, m_low);
    bus(`OFS_UNLOCK_KEY, {8'h00, `UNLOCK_KEY_SECOND}, 1'h1);
    wr_ctrl(m_new, m_low & 8'hBF);
    cmp_ctrl();
    @(posedge core_clk_in);
    one_way <= 1'h1;
    unlock();
    wr_ctrl(m_new, m_low & 8'hBF);
    cmp_ctrl();
    @(posedge core_clk_in);
    one_way <= 1'h0;
    unlock();
    wr_ctrl(m_new, m_low & 8'hBF);
    m_low[6] = 1'h0;
    check(pin_lock, 1'h0);
    // random switches with the pll locked
    @(posedge core_clk_in);
    pll_lock <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      sw({lfsr[2:1], 1'h1}, 1'h1);
      repeat (3) @(posedge core_clk_in);
      m_low[5] = (m_cur == `SEL_PLL_A || m_cur == `SEL_PLL_B);
      cmp_ctrl();
    end
    bus(`OFS_IRQ_STATUS, 16'h0000, 1'h0);
    check(rd_val[`IRQ_BIT_SWITCH_DONE], 1'h1);
    // start-up timer without lock, then a mode without the pll
    @(posedge core_clk_in);
    pll_lock <= 1'h0;
    sw(`SEL_PLL_A, 1'h1);
    cmp_ctrl();
    repeat (`PLL_START_CYCLES + 10) @(posedge core_clk_in);
    m_low[5] = 1'h1;
    cmp_ctrl();
    pll_lock <= 1'h1;
    sw(3'h0, 1'h1);
    repeat (3) @(posedge core_clk_in);
    cmp_ctrl();
    // selection freeze with and without the monitor
    @(posedge core_clk_in);
    mon_cfg <= 1'h1;
    wr_ctrl(m_new, m_low | 8'h80);
    m_low[7] = 1'h1;
    sw(3'h5, 1'h0);
    @(posedge core_clk_in);
    mon_cfg <= 1'h0;
    sw(3'h5, 1'h1);
    cmp_ctrl();
    // clock fail event, sticky flag and the interrupt path
    bus(`OFS_IRQ_STATUS, 16'h0007, 1'h1);
    bus(`OFS_IRQ_MASK, 16'h0001, 1'h1);
    @(posedge core_clk_in);
    fail_det <= 1'h1;
    @(posedge core_clk_in);
    fail_det <= 1'h0;
    m_low[3] = 1'h1;
    cmp_ctrl();
    irq_is(1'h1);
    bus(`OFS_IRQ_MASK, 16'h0000, 1'h1);
    irq_is(1'h0);
    bus(`OFS_IRQ_MASK, 16'h0001, 1'h1);
    irq_is(1'h1);
    bus(`OFS_IRQ_STATUS, 16'h0001, 1'h1);
    irq_is(1'h0);
    cmp_ctrl();
    wr_ctrl(m_new, m_low & 8'hF5);
    m_low[3] = 1'h0;
    m_low[1] = 1'h0;
    cmp_ctrl();
    check(sec_on, 1'h0);
    // second reset in mid-run picks up a new boot source
    @(posedge core_clk_in);
    init_sel <= 3'h4;
    rstn_in <= 1'h0;
    repeat (3) @(posedge core_clk_in);
    rstn_in <= 1'h1;
    repeat (2) @(posedge core_clk_in);
    {m_cur, m_new, m_low} = {3'h4, 3'h4, 8'h00};
    cmp_ctrl();
    summarize();
  end
  // watchdog, well past the few thousand cycles the sequence needs
  initial begin
    #300000;
    mismatches++;
    summarize();
  end
endmodule : testbench
bind oscillator_control_low_byte osc_ctrl_asserts chk_u (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in), .bus_req_in(bus_req_in),
  .rdata_out(rdata_out), .io_one_shot_config_in(io_one_shot_config_in),
  .sleep_in(sleep_in), .primary_osc_run_out(primary_osc_run_out),
  .secondary_osc_on_out(secondary_osc_on_out),
  .current_osc_out(current_osc_out), .switch_busy_out(switch_busy_out),
  .pin_map_lock_out(pin_map_lock_out));
